// ---- sadc_fmt.sv ----
/*
  sadc_pkg: constants of the converter sequencer. sadc_fmt: result formatter.
  assumes raw results are right aligned; 10-bit results use raw[9:0].
*/
package sadc_pkg;
  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHSEL = 8'h04;
  localparam logic [7:0] OFS_SCAN = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_THR = 8'h10;
  localparam logic [7:0] OFS_HIT = 8'h14;
  localparam logic [7:0] OFS_BUF = 8'h80;
  // control fields
  localparam int C_EN = 0;
  localparam int C_AUTO_SAMPLE_START = 1;
  localparam int C_SAMPLE_PHASE_BIT = 2;
  localparam int C_SRC = 4;
  localparam int C_SAMC = 8;
  localparam int C_SIGN = 13;
  localparam int C_LEFT = 14;
  localparam int C_M12 = 15;
  localparam int C_CHM = 16;
  localparam int C_IDX = 18;
  localparam int C_SPLIT = 19;
  localparam int C_SMPI = 20;
  localparam int C_ISEL = 24;
  localparam logic [31:0] CTRL_RST = 32'h0000_8000;
  localparam logic [31:0] CTRL_WMASK = 32'h03ff_fff3;
  // status fields
  localparam int S_DONE = 0;
  localparam int S_INT = 1;
  localparam int S_HALF = 2;
  localparam int S_STATE = 4;
  // codes
  localparam logic [3:0] SRC_SW = 4'h0;
  localparam logic [3:0] SRC_AUTO = 4'h7;
  localparam logic [1:0] CHM_ALT = 2'h1;
  localparam logic [1:0] CHM_SCAN = 2'h2;
  localparam logic [1:0] ISEL_HALF = 2'h1;
  localparam logic [1:0] ISEL_THR = 2'h2;
  // timing: one conversion clock period in CLK cycles
  localparam int CLK_NS = 100;
  localparam int TAD_NS = 400;
  localparam int TAD_CYC = (TAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXTRA_TAD = 2;
  // buffer
  localparam int BUF_DEPTH = 32;
  localparam logic [4:0] LAST_FULL = 5'h1f;
  localparam logic [4:0] LAST_HALF = 5'h0f;
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_SAMPLE = 2'b01,
    SADC_CONVERT = 2'b10
  } sadc_state_t;
endpackage

`timescale 1ns/1ps

// converts a raw code into one of the four presentation formats
module sadc_fmt
  import sadc_pkg::*;
(
  input wire logic [11:0] raw,
  input wire logic mode12,
  input wire logic signed_fmt,
  input wire logic left_fmt,
  output logic [15:0] word
);
  // ---------------------------------------------------------------
  // alignment and sign
  // ---------------------------------------------------------------
  wire [11:0] msb_al = mode12 ? raw : {raw[9:0], 2'b00};
  // signed form is offset binary with the top bit flipped
  wire [11:0] sv = signed_fmt ? {~msb_al[11], msb_al[10:0]} : msb_al;
  wire [15:0] r12 = {{4{signed_fmt & sv[11]}}, sv};
  wire [15:0] r10 = {{6{signed_fmt & sv[11]}}, sv[11:2]};
  assign word = left_fmt ? {sv, 4'h0} : (mode12 ? r12 : r10);
endmodule

// ---- sadc_seq.sv ----
/*
  sadc_seq: sample/convert sequencer, SAR control, result buffer and
  AHB-Lite register slave. assumes the analog core follows SH_SAMPLE and
  DAC_CODE within one conversion clock period and drives COMP_IN in sync.
*/
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps

// Overview of operation
// - one period per bit plus two
// - every result stored in buffer automatically, except threshold misses
// - trigger ends sampling, starts conversion
// - auto-convert timed by conversion clock counter
// - nonzero count extends sampling, zero converts
// - auto-sample alternates sample and convert
// - idle before start and after software conversion
// - sample leads straight to short convert
// - hold closes at sample-to-convert edge
// - single, alternate or bit-map scan channels
// - 12/10 bit, signed/unsigned, left/right
// - buffer is FIFO or channel indexed
// - FIFO may split into two halves
// - indexed threshold keeps matches, sets hit flags
// - interrupt on count, half, or threshold
// - interrupt resets scan and write pointer
// - buffer depth covers channels, even count
// - source codes: software, auto, trigger inputs
// - auto-start samples right after conversion
// - sample bit shows acquire versus hold
// - done set on completion, cleared when the next sampling ends
module sadc_seq
  import sadc_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic [15:0] TRIG_IN,
  input wire logic COMP_IN,
  output logic SH_SAMPLE,
  output logic [11:0] DAC_CODE,
  output logic [4:0] CH_SEL,
  output logic DONE,
  output logic INT_FLAG
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg, chsel_reg, scan_reg, thr_reg, hit_reg, rdata_reg;
  logic int_reg, done_reg, half_reg, alt_reg, wr_pend_reg;
  logic [7:0] wr_addr_reg;
  sadc_state_t state_reg, state_next;
  logic [2:0] tad_cnt_reg;
  logic [3:0] step_reg;
  logic [4:0] sample_phase_bit_cnt_reg, ch_reg, ch_next, wr_ptr_reg, conv_cnt_reg;
  logic [11:0] sar_reg, bit_reg;
  logic [15:0] trig_prev_reg;
  logic [15:0] buf_mem [BUF_DEPTH];
  logic [15:0] fmt_word;

  // address decode, shared by read and write phases
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == OFS_CTRL) reg_sel = 3'h1;
    else if (a == OFS_CHSEL) reg_sel = 3'h2;
    else if (a == OFS_SCAN) reg_sel = 3'h3;
    else if (a == OFS_STAT) reg_sel = 3'h4;
    else if (a == OFS_THR) reg_sel = 3'h5;
    else if (a == OFS_HIT) reg_sel = 3'h6;
    else if (a[7] && a[1:0] == 2'b00) reg_sel = 3'h7;
    else reg_sel = 3'h0;
  endfunction

  // next set bit of the scan map after cur, wrapping; cur if map empty
  function automatic logic [4:0] next_scan(input logic [31:0] map, input logic [4:0] cur);
    logic [4:0] c;
    logic hit;
    next_scan = cur;
    hit = 1'b0;
    for (int i = 1; i <= 32; i++) begin
      c = cur + i[4:0];
      if (!hit && map[c]) begin
        next_scan = c;
        hit = 1'b1;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  wire en = ctrl_reg[C_EN];
  wire auto_sample_start = ctrl_reg[C_AUTO_SAMPLE_START];
  wire [3:0] src = ctrl_reg[C_SRC +: 4];
  wire [4:0] samc = ctrl_reg[C_SAMC +: 5];
  wire mode12 = ctrl_reg[C_M12];
  wire [1:0] chm = ctrl_reg[C_CHM +: 2];
  wire idx_mode = ctrl_reg[C_IDX];
  wire split = ctrl_reg[C_SPLIT];
  wire [3:0] smpi = ctrl_reg[C_SMPI +: 4];
  wire [1:0] isel = ctrl_reg[C_ISEL +: 2];
  wire [4:0] chan_a = chsel_reg[4:0];
  wire [4:0] chan_b = chsel_reg[12:8];
  wire [11:0] thr_lo = thr_reg[11:0];
  wire [11:0] thr_hi = thr_reg[27:16];

  // ---------------------------------------------------------------
  // bus slave, zero wait states, always OKAY
  // ---------------------------------------------------------------
  wire addr_ok = HSEL & HREADY & HTRANS[1];
  wire [2:0] rsel = reg_sel(HADDR[7:0]);
  wire [2:0] wsel = reg_sel(wr_addr_reg);
  wire wr_ctrl = wr_pend_reg & (wsel == 3'h1);
  wire wr_stat = wr_pend_reg & (wsel == 3'h4);
  wire wr_hit = wr_pend_reg & (wsel == 3'h6);
  wire [31:0] stat_word = {26'h0, state_reg, 1'b0, half_reg, int_reg, done_reg};
  wire [31:0] ctrl_word = {ctrl_reg[31:3], state_reg == SADC_SAMPLE, ctrl_reg[1:0]};
  wire [31:0] rd_mux = (rsel == 3'h1) ? ctrl_word :
                       (rsel == 3'h2) ? chsel_reg :
                       (rsel == 3'h3) ? scan_reg :
                       (rsel == 3'h4) ? stat_word :
                       (rsel == 3'h5) ? thr_reg :
                       (rsel == 3'h6) ? hit_reg :
                       (rsel == 3'h7) ? {16'h0, buf_mem[HADDR[6:2]]} : 32'h0;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_reg;

  // software sample control: writing the sample bit sets or clears it
  wire sw_sample_phase_bit_set = wr_ctrl & HWDATA[C_SAMPLE_PHASE_BIT];
  wire sw_sample_phase_bit_clr = wr_ctrl & ~HWDATA[C_SAMPLE_PHASE_BIT];

  // ---------------------------------------------------------------
  // sequencer decisions
  // ---------------------------------------------------------------
  wire in_sample_phase_bit = state_reg == SADC_SAMPLE;
  wire in_conv = state_reg == SADC_CONVERT;
  wire tad_tick = tad_cnt_reg == 3'(TAD_CYC - 1);
  wire [3:0] nbits = mode12 ? 4'd12 : 4'd10;
  wire [3:0] last_step = 4'(nbits + 4'(EXTRA_TAD) - 4'd1);
  wire conv_end = in_conv & tad_tick & (step_reg == last_step);
  wire [15:0] trig_edge = TRIG_IN & ~trig_prev_reg;
  // auto-convert: zero count ends sampling at once, else after samc periods
  wire auto_due = sample_phase_bit_cnt_reg >= samc;
  wire end_sample_phase_bit = in_sample_phase_bit & ((src == SRC_SW) ? sw_sample_phase_bit_clr :
                             (src == SRC_AUTO) ? auto_due : trig_edge[src]);
  wire start_sample_phase_bit = (state_reg == SADC_IDLE) & en & (sw_sample_phase_bit_set | auto_sample_start);

  // state transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SADC_IDLE: if (start_sample_phase_bit) state_next = SADC_SAMPLE;
      SADC_SAMPLE: if (end_sample_phase_bit) state_next = SADC_CONVERT;
      // auto-sample returns to sampling, otherwise rest idle
      SADC_CONVERT: if (conv_end) state_next = auto_sample_start ? SADC_SAMPLE : SADC_IDLE;
      default: state_next = SADC_IDLE;
    endcase
    if (!en) state_next = SADC_IDLE;
  end

  // ---------------------------------------------------------------
  // result path
  // ---------------------------------------------------------------
  sadc_fmt u_fmt (
    .raw(sar_reg),
    .mode12(mode12),
    .signed_fmt(ctrl_reg[C_SIGN]),
    .left_fmt(ctrl_reg[C_LEFT]),
    .word(fmt_word)
  );

  wire thr_on = idx_mode & (isel == ISEL_THR);
  wire thr_match = (sar_reg >= thr_lo) & (sar_reg <= thr_hi);
  wire keep = ~thr_on | thr_match;
  wire [4:0] fifo_last = split ? LAST_HALF : LAST_FULL;
  wire [4:0] fifo_addr = split ? {half_reg, wr_ptr_reg[3:0]} : wr_ptr_reg;
  wire [4:0] buf_addr = idx_mode ? ch_reg : fifo_addr;
  wire buf_we = conv_end & keep;
  wire [4:0] conv_cnt_inc = conv_cnt_reg + 5'd1;
  wire int_ev = conv_end & ((isel == ISEL_THR) ? thr_on & thr_match :
                (isel == ISEL_HALF) ? ~idx_mode & (wr_ptr_reg == fifo_last) :
                (conv_cnt_inc == {1'b0, smpi} + 5'd1));
  wire [4:0] scan_first = next_scan(scan_reg, 5'h1f);

  // channel selection for the next conversion
  always_comb begin
    ch_next = ch_reg;
    if (state_reg == SADC_IDLE || (conv_end && int_ev)) begin
      ch_next = (chm == CHM_SCAN) ? scan_first : chan_a;
    end else if (conv_end) begin
      if (chm == CHM_SCAN) ch_next = next_scan(scan_reg, ch_reg);
      else if (chm == CHM_ALT) ch_next = alt_reg ? chan_a : chan_b;
      else ch_next = chan_a;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // bus phase capture and software registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0;
      ctrl_reg <= CTRL_RST;
      chsel_reg <= 32'h0;
      scan_reg <= 32'h0;
      thr_reg <= 32'h0;
    end else begin
      wr_pend_reg <= addr_ok & HWRITE;
      wr_addr_reg <= HADDR[7:0];
      if (addr_ok && !HWRITE) rdata_reg <= rd_mux;
      if (wr_ctrl) ctrl_reg <= HWDATA & CTRL_WMASK;
      if (wr_pend_reg && wsel == 3'h2) chsel_reg <= HWDATA & 32'h0000_1f1f;
      if (wr_pend_reg && wsel == 3'h3) scan_reg <= HWDATA;
      if (wr_pend_reg && wsel == 3'h5) thr_reg <= HWDATA & 32'h0fff_0fff;
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      int_reg <= 1'b0;
      hit_reg <= 32'h0;
      done_reg <= 1'b0;
    end else begin
      int_reg <= int_ev | (int_reg & ~(wr_stat & HWDATA[S_INT]));
      hit_reg <= (hit_reg & ~({32{wr_hit}} & HWDATA)) |
                 ({32{conv_end & thr_on & thr_match}} & (32'h1 << ch_reg));
      if (conv_end) done_reg <= 1'b1;
      else if (end_sample_phase_bit) done_reg <= 1'b0;
    end
  end

  // sequencer and conversion-clock timing
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= SADC_IDLE;
      tad_cnt_reg <= 3'h0;
      step_reg <= 4'h0;
      sample_phase_bit_cnt_reg <= 5'h0;
      trig_prev_reg <= 16'h0;
    end else begin
      state_reg <= state_next;
      trig_prev_reg <= TRIG_IN;
      // restart the period counter on every state change
      if (state_next != state_reg || tad_tick) tad_cnt_reg <= 3'h0;
      else tad_cnt_reg <= tad_cnt_reg + 3'h1;
      if (!in_sample_phase_bit) sample_phase_bit_cnt_reg <= 5'h0;
      else if (tad_tick && !auto_due) sample_phase_bit_cnt_reg <= sample_phase_bit_cnt_reg + 5'h1;
      if (!in_conv) step_reg <= 4'h0;
      else if (tad_tick) step_reg <= step_reg + 4'h1;
    end
  end

  // successive approximation: period 0 settles, then one bit per period
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sar_reg <= 12'h0;
      bit_reg <= 12'h0;
    end else if (end_sample_phase_bit) begin
      sar_reg <= 12'h0;
      bit_reg <= mode12 ? 12'h800 : 12'h200;
    end else if (in_conv && tad_tick && step_reg != 4'h0 && step_reg <= nbits) begin
      if (COMP_IN) sar_reg <= sar_reg | bit_reg;
      bit_reg <= bit_reg >> 1;
    end
  end

  // buffer write and pointers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_ptr_reg <= 5'h0;
      conv_cnt_reg <= 5'h0;
      half_reg <= 1'b0;
      alt_reg <= 1'b0;
      ch_reg <= 5'h0;
    end else begin
      ch_reg <= ch_next;
      if (state_reg == SADC_IDLE && !en) begin
        wr_ptr_reg <= 5'h0;
        conv_cnt_reg <= 5'h0;
        half_reg <= 1'b0;
        alt_reg <= 1'b0;
      end else if (conv_end) begin
        alt_reg <= int_ev ? 1'b0 : ~alt_reg;
        conv_cnt_reg <= int_ev ? 5'h0 : conv_cnt_inc;
        if (int_ev) begin
          wr_ptr_reg <= 5'h0;
          half_reg <= split & ~half_reg;
        end else if (!idx_mode) begin
          wr_ptr_reg <= (wr_ptr_reg >= fifo_last) ? 5'h0 : wr_ptr_reg + 5'h1;
        end
      end
    end
  end

  // result memory has no reset; contents survive disable
  always_ff @(posedge CLK) begin
    if (buf_we) buf_mem[buf_addr] <= fmt_word;
  end

  // ---------------------------------------------------------------
  // analog side
  // ---------------------------------------------------------------
  assign SH_SAMPLE = in_sample_phase_bit;
  assign DAC_CODE = in_conv ? (sar_reg | bit_reg) : 12'h0;
  assign CH_SEL = ch_reg;
  assign DONE = done_reg;
  assign INT_FLAG = int_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence conv_entry;
    $rose(in_conv);
  endsequence
  // cycles spent in the current conversion; a counter keeps the length check cheap
  logic [5:0] conv_age_reg;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) conv_age_reg <= 6'h0;
    else conv_age_reg <= in_conv ? conv_age_reg + 6'h1 : 6'h0;
  end
  a_conv_len_twelve: assert property (@(posedge CLK) disable iff (!NRST)
    conv_end && mode12 |-> conv_age_reg == 6'((12 + EXTRA_TAD) * TAD_CYC - 1))
    else $error("12-bit conversion did not last 14 periods");
  a_conv_not_early: assert property (@(posedge CLK) disable iff (!NRST)
    conv_entry |-> !conv_end [*8])
    else $error("conversion ended too soon");
  a_sample_phase_bit_then_conv: assert property (@(posedge CLK) disable iff (!NRST)
    in_sample_phase_bit && end_sample_phase_bit && en |=> in_conv && !SH_SAMPLE)
    else $error("trigger did not start conversion");
  a_auto_restart: assert property (@(posedge CLK) disable iff (!NRST)
    conv_end && auto_sample_start && en |=> SH_SAMPLE)
    else $error("auto-sample did not resume sampling");
  a_sw_idle: assert property (@(posedge CLK) disable iff (!NRST)
    conv_end && !auto_sample_start |=> state_reg == SADC_IDLE)
    else $error("software conversion did not return idle");
  a_auto_zero: assert property (@(posedge CLK) disable iff (!NRST)
    in_sample_phase_bit && src == SRC_AUTO && samc == 5'h0 && en |=> in_conv)
    else $error("zero auto count did not convert at once");
  a_done_cycle: assert property (@(posedge CLK) disable iff (!NRST)
    conv_end |=> DONE ##1 (DONE != $past(end_sample_phase_bit)))
    else $error("done flag not held after completion");
  a_int_rewind: assert property (@(posedge CLK) disable iff (!NRST)
    int_ev |=> wr_ptr_reg == 5'h0 && INT_FLAG && conv_cnt_reg == 5'h0)
    else $error("interrupt did not rewind pointers");
  a_int_sticky: assert property (@(posedge CLK) disable iff (!NRST)
    int_ev && wr_stat |=> INT_FLAG)
    else $error("interrupt lost against a clear");
  a_fifo_step: assert property (@(posedge CLK) disable iff (!NRST)
    conv_end && !int_ev && !idx_mode && en && wr_ptr_reg < fifo_last
      |=> wr_ptr_reg == $past(wr_ptr_reg) + 5'h1)
    else $error("fifo pointer did not advance by one");
endmodule

// ---- sadc_core_model.sv ----
/*
  sadc_core_model: behavioural analog side of the sequencer, a sample-and-hold
  with a comparator. assumes the digital side moves dac_code on period ticks only.
*/
`timescale 1ns/1ps

// ------------------------------------------------------------
// analog core model
// ------------------------------------------------------------
module sadc_core_model (
  input wire logic clk,
  input wire logic sh_sample,
  input wire logic [11:0] dac_code,
  input wire logic [4:0] ch_sel,
  input wire logic [11:0] vin [32],
  input wire logic slow,
  output logic comp_out
);
  logic [11:0] held_reg;
  logic cmp_reg;
  logic junk_reg = 1'b0;
  // aperture closes as sampling ends; later input moves are ignored
  always @(negedge sh_sample) held_reg <= vin[ch_sel];
  // slow variant answers a clock late, still well inside one period
  always_ff @(posedge clk) begin
    cmp_reg <= held_reg >= dac_code;
    junk_reg <= ~junk_reg;
  end
  // while acquiring the output means nothing, so it toggles every cycle
  assign comp_out = sh_sample ? junk_reg : (slow ? cmp_reg : held_reg >= dac_code);
endmodule

// ---- sadc_seq_tb.sv ----
/*
  sadc_seq_tb: self-checking bench of the converter sequencer with an analog model.
  assumes one 10 MHz clock and the register map of sadc_pkg.
*/
`timescale 1ns/1ps

module sadc_seq_tb import sadc_pkg::*;;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [15:0] TRIG_IN = 16'h0;
  logic slow = 1'b0;
  logic HREADYOUT, HRESP, COMP_IN, SH_SAMPLE, DONE, INT_FLAG;
  logic [31:0] HRDATA;
  logic [11:0] DAC_CODE;
  logic [4:0] CH_SEL;
  logic [11:0] vin [32];
  logic [31:0] lfsr = 32'hed40;
  logic [1:0] fl = 2'h0;
  logic m10 = 1'b0;
  int fail_count = 0, total_checks = 0, wp = 0, cyc = 0, t_fall = 0, t_rise = 0;
  int conv_len = 0, sample_phase_bit_len = 0, done_cnt = 0;
  logic sh_q = 1'b0, done_q = 1'b0, sh_at_done = 1'b0;
  logic [4:0] starts [$];

  always #50 CLK = ~CLK;

  sadc_seq i_sadc_seq (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .TRIG_IN(TRIG_IN),
    .COMP_IN(COMP_IN), .SH_SAMPLE(SH_SAMPLE), .DAC_CODE(DAC_CODE), .CH_SEL(CH_SEL),
    .DONE(DONE), .INT_FLAG(INT_FLAG));
  sadc_core_model i_sadc_core_model (.clk(CLK), .sh_sample(SH_SAMPLE), .dac_code(DAC_CODE),
    .ch_sel(CH_SEL), .vin(vin), .slow(slow), .comp_out(COMP_IN));

  // ------------------------------------------------------------
  // expectation helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = lfsr[0] ? ((lfsr >> 1) ^ 32'h8020_0003) : (lfsr >> 1);
    return lfsr;
  endfunction
  function automatic logic [31:0] cfg(input logic [3:0] src, input logic [4:0] samc,
      input logic [1:0] chm, input logic [1:0] isel, input logic [3:0] smpi, input logic [1:0] bm);
    return (32'h1 << C_EN) | ({31'h0, ~m10} << C_M12) | ({28'h0, src} << C_SRC)
      | ({27'h0, samc} << C_SAMC) | ({30'h0, fl} << C_SIGN) | ({30'h0, chm} << C_CHM)
      | ({30'h0, bm} << C_IDX) | ({28'h0, smpi} << C_SMPI) | ({30'h0, isel} << C_ISEL);
  endfunction
  // offset binary with the top bit flipped for signed, sign-extended when right aligned;
  // a 10-bit code is first moved to the top of the 12-bit field
  function automatic logic [15:0] fmt_exp(input logic [11:0] raw);
    logic [11:0] r;
    r = m10 ? {raw[9:0], 2'b00} : raw;
    r = fl[0] ? (r ^ 12'h800) : r;
    if (fl[1]) return {r, 4'h0};
    if (m10) return {{6{fl[0] & r[11]}}, r[11:2]};
    return {{4{fl[0] & r[11]}}, r};
  endfunction
  function automatic logic [4:0] exp_ch(input logic [1:0] m, input int k,
      input logic [31:0] map, input logic [4:0] a, input logic [4:0] b);
    int n;
    n = 0;
    if (m == CHM_ALT) return k[0] ? b : a;
    if (m != CHM_SCAN) return a;
    for (int i = 0; i < 32; i++) begin
      if (map[i]) begin
        if (n == k % $countones(map)) return 5'(i);
        n++;
      end
    end
    return a;
  endfunction

  // ------------------------------------------------------------
  // bus, compare and wait tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask
  // bounded wait on conversion completions or conversion starts; a timeout is a mismatch
  task automatic wait_for(input bit on_starts, input int target);
    int k;
    k = 0;
    while ((on_starts ? starts.size() : done_cnt) < target && k < 5000) begin
      @(posedge CLK);
      k++;
    end
    if (k == 5000) fail_count++;
  endtask
  task automatic do_reset();
    NRST <= 1'b0;
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    wp = 0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // monitor: times sampling and conversion, logs converted channels
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    cyc++;
    if (sh_q && !SH_SAMPLE) begin
      t_fall = cyc;
      sample_phase_bit_len = cyc - t_rise;
      starts.push_back(CH_SEL);
    end
    if (!sh_q && SH_SAMPLE) t_rise = cyc;
    if (!done_q && DONE) begin
      conv_len = cyc - t_fall;
      sh_at_done = SH_SAMPLE;
      done_cnt++;
    end
    if (cyc == t_fall + 2) chk({31'h0, DONE}, 32'h0);
    sh_q = SH_SAMPLE;
    done_q = DONE;
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // checks after one single-shot conversion; the count interrupt rewinds the fifo every 16 results
  task automatic post(input logic [11:0] raw);
    chk(32'(conv_len), 32'(((m10 ? 10 : 12) + EXTRA_TAD) * TAD_CYC));
    chk({31'h0, sh_at_done}, 32'h0);
    rdchk(OFS_BUF + 8'(4 * wp), {16'h0, fmt_exp(raw)});
    wp = (wp + 1) % 16;
    chk({31'h0, INT_FLAG}, {31'h0, wp == 0});
    if (wp == 0) wr(OFS_STAT, 32'h2);
    rdchk(OFS_STAT, 32'h1);
  endtask
  // one conversion ended by software or by a trigger input; a wrong input comes first
  task automatic one_conv(input logic [3:0] src);
    logic [11:0] raw;
    logic [4:0] ch;
    ch = 5'(rnd());
    m10 = src[2] & src[0];
    raw = 12'(rnd()) & (m10 ? 12'h3ff : 12'hfff);
    vin[ch] = raw;
    fl = 2'(src);
    slow <= src[1];
    wr(OFS_CHSEL, {27'h0, ch});
    // enable first: the sample bit only starts sampling once the block is on
    wr(OFS_CTRL, cfg(src, 5'h0, 2'h0, 2'h0, 4'hf, 2'h0));
    wr(OFS_CTRL, cfg(src, 5'h0, 2'h0, 2'h0, 4'hf, 2'h0) | (32'h1 << C_SAMPLE_PHASE_BIT));
    repeat (6) @(posedge CLK);
    chk({31'h0, SH_SAMPLE}, 32'h1);
    if (src == SRC_SW) begin
      wr(OFS_CTRL, cfg(src, 5'h0, 2'h0, 2'h0, 4'hf, 2'h0));
    end else begin
      TRIG_IN <= 16'h1 << (src ^ 4'h1);
      repeat (4) @(posedge CLK);
      TRIG_IN <= 16'h0;
      repeat (4) @(posedge CLK);
      chk({31'h0, SH_SAMPLE}, 32'h1);
      TRIG_IN <= 16'h1 << src;
    end
    repeat (6) @(posedge CLK);
    vin[ch] = ~raw;
    TRIG_IN <= 16'h0;
    wait_for(1'b0, done_cnt + 1);
    post(raw);
  endtask
  // free-running sample/convert, interrupt every 4 results, stopped in the sixth
  task automatic auto_run(input logic [1:0] chm, input logic [4:0] samc, input logic [31:0] map);
    int s0;
    logic [4:0] a;
    logic [4:0] b;
    logic [4:0] e;
    a = 5'(rnd());
    b = 5'(rnd());
    do_reset();
    fl = 2'(rnd());
    m10 = 1'b0;
    s0 = starts.size();
    wr(OFS_CHSEL, {19'h0, b, 3'h0, a});
    wr(OFS_SCAN, map);
    wr(OFS_CTRL, cfg(SRC_AUTO, samc, chm, 2'h0, 4'h3, 2'h0) | (32'h1 << C_AUTO_SAMPLE_START));
    wait_for(1'b1, s0 + 6);
    wr(OFS_CTRL, 32'h0);
    for (int k = 0; k < 6; k++) begin
      e = exp_ch(chm, k % 4, map, a, b);
      chk({27'h0, starts[s0 + k]}, {27'h0, e});
    end
    // the sample state always holds one cycle after the count periods run
    chk(32'(sample_phase_bit_len), 32'(TAD_CYC * samc + 1));
    chk({31'h0, sh_at_done}, 32'h1);
    chk({31'h0, INT_FLAG}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      e = exp_ch(chm, k, map, a, b);
      rdchk(OFS_BUF + 8'(4 * k), {16'h0, fmt_exp(vin[e])});
    end
  endtask

  initial begin
    int d0;
    int s0;
    logic [31:0] old;
    for (int k = 0; k < 32; k++) vin[k] = 12'(rnd());
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    rdchk(OFS_CTRL, CTRL_RST);
    rdchk(OFS_STAT, 32'h0);
    chk({30'h0, SH_SAMPLE, HRESP}, 32'h0);
    for (int i = 0; i < 18; i++) if (i != 7) one_conv(4'(i));
    auto_run(2'h0, 5'h0, 32'h0);
    auto_run(CHM_ALT, 5'(1 + rnd() % 7), 32'h0);
    auto_run(CHM_SCAN, 5'(rnd() % 8), (rnd() & rnd()) | 32'h0000_0100);
    // indexed threshold: channel 20 out of window, 27 on its upper edge
    do_reset();
    fl = 2'h0;
    bus(1'b0, OFS_BUF + 8'(4 * 20), 32'h0, old);
    vin[20] = 12'hf00;
    vin[27] = 12'h500;
    s0 = starts.size();
    wr(OFS_THR, 32'h0500_0300);
    wr(OFS_SCAN, 32'h0810_0000);
    wr(OFS_CTRL, cfg(SRC_AUTO, 5'h1, CHM_SCAN, ISEL_THR, 4'h0, 2'h1) | (32'h1 << C_AUTO_SAMPLE_START));
    wait_for(1'b1, s0 + 3);
    wr(OFS_CTRL, 32'h0);
    chk({27'h0, starts[s0 + 2]}, 32'd20);
    rdchk(OFS_HIT, 32'h0800_0000);
    rdchk(OFS_BUF + 8'(4 * 27), 32'h0000_0500);
    rdchk(OFS_BUF + 8'(4 * 20), old);
    chk({31'h0, INT_FLAG}, 32'h1);
    // split fifo: the first half fills after 16 results
    do_reset();
    d0 = done_cnt;
    wr(OFS_CTRL, cfg(SRC_AUTO, 5'h0, 2'h0, ISEL_HALF, 4'h0, 2'h2) | (32'h1 << C_AUTO_SAMPLE_START));
    for (int k = 0; k < 3000 && INT_FLAG !== 1'b1; k++) @(posedge CLK);
    @(posedge CLK);
    chk(32'(done_cnt - d0), 32'(LAST_HALF) + 32'd1);
    bus(1'b0, OFS_STAT, 32'h0, old);
    chk({31'h0, old[S_HALF]}, 32'h1);
    wr(OFS_CTRL, 32'h0);
    end_of_test();
  end

  // watchdog, far beyond the few thousand cycles the scenarios need
  initial begin
    repeat (40000) @(posedge CLK);
    fail_count++;
    end_of_test();
  end
endmodule
